// file: src/power_mode_controller.sv
// Power mode sequencer: normal, idle, stop and shutdown.
`timescale 1ns/100ps
module power_mode_controller
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Firmware control from the CPU core.
  input wire logic halt_req_set_i,
  input wire logic stop_req_set_i,
  input wire logic regulator_off_select_i,
  input wire logic instr_done_i,
  // Wake sources and comparator enable.
  input wire logic irq_enabled_pending_i,
  input wire logic int_reset_i,
  input wire logic pin_reset_n_i,
  input wire logic supply_low_i,
  input wire logic comparator_enable_i,
  // Core and power control.
  output logic cpu_run_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic regulator_en_o,
  output logic comparator_run_o,
  output logic core_reset_o,
  output logic [15:0] fetch_addr_o,
  output logic fetch_load_o,
  output logic resume_next_o,
  output logic [1:0] clk_sel_o,
  // Status.
  output logic halt_req_o,
  output logic stop_req_o,
  output logic [1:0] mode_o
);

  import pwr_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic pin_reset_n_sync;
  logic supply_low_sync;
  logic pin_reset_sync;
  logic any_reset;

  // Pins from outside the clock domain pass two flip-flops.
  sync_2ff u_sync_pin
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(~pin_reset_n_i),
    .sync_o(pin_reset_sync)
  );

  sync_2ff u_sync_supply
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(supply_low_i),
    .sync_o(supply_low_sync)
  );

  assign pin_reset_n_sync = ~pin_reset_sync;

  // An internal, pin or supply reset each counts as a reset source.
  assign any_reset = int_reset_i | pin_reset_sync | supply_low_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.

  power_mode_type mode_reg;
  power_mode_type mode_next;
  logic [2:0] seq_cnt_reg;
  logic pending_halt_reg;
  logic pending_stop_reg;
  logic pending_reg_off_reg;
  logic wake_reset;

  // Shutdown leaves only on a pin or supply reset.
  always_comb
  begin
    if (mode_reg == MODE_SHUTDOWN)
      wake_reset = pin_reset_sync | supply_low_sync;
    else
      wake_reset = any_reset;
  end

  // Next mode selection.
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_NORMAL:
      begin
        if (wake_reset)
          mode_next = MODE_RESET_SEQ;
        else if (instr_done_i && pending_stop_reg && pending_reg_off_reg)
          mode_next = MODE_SHUTDOWN;
        else if (instr_done_i && pending_stop_reg)
          mode_next = MODE_STOP;
        else if (instr_done_i && pending_halt_reg)
          mode_next = MODE_IDLE;
      end
      MODE_IDLE:
      begin
        if (wake_reset)
          mode_next = MODE_RESET_SEQ;
        else if (irq_enabled_pending_i)
          mode_next = MODE_NORMAL;
      end
      MODE_STOP:
      begin
        if (wake_reset)
          mode_next = MODE_RESET_SEQ;
      end
      MODE_SHUTDOWN:
      begin
        if (wake_reset)
          mode_next = MODE_RESET_SEQ;
      end
      MODE_RESET_SEQ:
      begin
        if (!supply_low_sync && !pin_reset_sync && !int_reset_i &&
            seq_cnt_reg == RESET_SEQ_LAST)
          mode_next = MODE_NORMAL;
      end
      default:
        mode_next = MODE_RESET_SEQ;
    endcase
  end

  // Mode register; the low supply holds the sequence in reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_reg <= MODE_RESET_SEQ;
    else
      mode_reg <= mode_next;
  end

  // Reset sequence counter restarts while any reset source is active.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seq_cnt_reg <= 3'h0;
    else if (mode_reg != MODE_RESET_SEQ || any_reset)
      seq_cnt_reg <= 3'h0;
    else if (seq_cnt_reg != RESET_SEQ_LAST)
      seq_cnt_reg <= seq_cnt_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request bits set by firmware.

  // Halt request; interrupt wake clears it, set wins over clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pending_halt_reg <= RESET_HALT_REQ;
    else if (mode_reg == MODE_RESET_SEQ)
      pending_halt_reg <= RESET_HALT_REQ;
    else if (halt_req_set_i && mode_reg == MODE_NORMAL)
      pending_halt_reg <= 1'b1;
    else if (mode_reg == MODE_IDLE && mode_next == MODE_NORMAL)
      pending_halt_reg <= 1'b0;
  end

  // Stop request and the captured regulator select.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pending_stop_reg <= RESET_STOP_REQ;
      pending_reg_off_reg <= RESET_REG_OFF;
    end
    else if (mode_reg == MODE_RESET_SEQ)
    begin
      pending_stop_reg <= RESET_STOP_REQ;
      pending_reg_off_reg <= RESET_REG_OFF;
    end
    else if (stop_req_set_i && mode_reg == MODE_NORMAL)
    begin
      pending_stop_reg <= 1'b1;
      pending_reg_off_reg <= regulator_off_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Power and clock controls follow the next mode.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cpu_run_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_en_o <= 1'b1;
      regulator_en_o <= 1'b1;
      comparator_run_o <= 1'b0;
      core_reset_o <= 1'b1;
      clk_sel_o <= CLK_SEL_LOW_POWER_OSC;
      mode_o <= MODE_CODE_NORMAL;
    end
    else
    begin
      cpu_run_o <= (mode_next == MODE_NORMAL);
      periph_clk_en_o <= (mode_next == MODE_NORMAL) ||
                         (mode_next == MODE_IDLE);
      osc_en_o <= (mode_next != MODE_STOP) &&
                  (mode_next != MODE_SHUTDOWN);
      regulator_en_o <= (mode_next != MODE_SHUTDOWN);
      comparator_run_o <= comparator_enable_i &&
                          (mode_next != MODE_SHUTDOWN);
      core_reset_o <= (mode_next == MODE_RESET_SEQ);
      if (mode_next == MODE_RESET_SEQ)
        clk_sel_o <= CLK_SEL_LOW_POWER_OSC;
      case (mode_next)
        MODE_IDLE: mode_o <= MODE_CODE_IDLE;
        MODE_STOP: mode_o <= MODE_CODE_STOP;
        MODE_SHUTDOWN: mode_o <= MODE_CODE_SHUTDOWN;
        default: mode_o <= MODE_CODE_NORMAL;
      endcase
    end
  end

  // Fetch control: vector load after reset, resume after idle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fetch_addr_o <= RESET_VECTOR;
      fetch_load_o <= 1'b0;
      resume_next_o <= 1'b0;
    end
    else
    begin
      fetch_addr_o <= RESET_VECTOR;
      fetch_load_o <= (mode_reg == MODE_RESET_SEQ) &&
                      (mode_next == MODE_NORMAL);
      resume_next_o <= (mode_reg == MODE_IDLE) &&
                       (mode_next == MODE_NORMAL);
    end
  end

  // Status copies of the request bits.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_req_o <= 1'b0;
      stop_req_o <= 1'b0;
    end
    else
    begin
      halt_req_o <= pending_halt_reg;
      stop_req_o <= pending_stop_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  idle_irq_wake_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_reg == MODE_IDLE && irq_enabled_pending_i && !any_reset)
      |=> (mode_reg == MODE_NORMAL && !pending_halt_reg))
    else $error("idle did not wake on interrupt");

  stop_no_irq_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_reg == MODE_STOP && !any_reset) |=> mode_reg == MODE_STOP)
    else $error("stop left without reset");

  shutdown_exit_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_reg == MODE_SHUTDOWN && !pin_reset_sync && !supply_low_sync)
      |=> mode_reg == MODE_SHUTDOWN)
    else $error("shutdown left without pin or power reset");

  shutdown_reg_off_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_reg == MODE_SHUTDOWN) |=> (!regulator_en_o || mode_reg !=
      MODE_SHUTDOWN))
    else $error("regulator on in shutdown");

  stop_osc_off_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(mode_reg == MODE_STOP) |-> (!osc_en_o && !cpu_run_o &&
      regulator_en_o))
    else $error("stop controls wrong");

  idle_periph_run_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(mode_reg == MODE_IDLE) |-> (periph_clk_en_o && !cpu_run_o))
    else $error("idle controls wrong");

  supply_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    supply_low_sync |=> (core_reset_o && mode_reg == MODE_RESET_SEQ))
    else $error("low supply did not hold reset");

  reset_clears_req_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_reg == MODE_RESET_SEQ) |=> (!pending_stop_reg &&
      !pending_halt_reg))
    else $error("request bits survived reset");

  reset_vector_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    fetch_load_o |-> (fetch_addr_o == RESET_VECTOR && cpu_run_o))
    else $error("bad reset fetch");

  idle_cov: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_reg == MODE_IDLE ##1 mode_reg == MODE_NORMAL);
  stop_cov: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_reg == MODE_STOP ##1 mode_reg == MODE_RESET_SEQ);
  shutdown_cov: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_reg == MODE_SHUTDOWN ##1 mode_reg == MODE_RESET_SEQ);

endmodule

// file: include/pwr_mode_pkg.sv
// Package of constants and types for the power mode controller.
package pwr_mode_pkg;

  // Power mode states of the sequencer.
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_STOP,
    MODE_SHUTDOWN,
    MODE_RESET_SEQ
  } power_mode_type;

  // Encoded mode shown on the status output.
  localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_CODE_STOP = 2'h2;
  localparam logic [1:0] MODE_CODE_SHUTDOWN = 2'h3;

  // Reset vector where fetching starts after any reset.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Length of the internal reset sequence in clock cycles.
  localparam int RESET_SEQ_CYCLES = 4;
  localparam logic [2:0] RESET_SEQ_LAST = 3'(RESET_SEQ_CYCLES - 1);

  // Clock source selection codes; zero is the low-power oscillator.
  localparam logic [1:0] CLK_SEL_LOW_POWER_OSC = 2'h0;

  // Values after reset.
  localparam logic RESET_HALT_REQ = 1'b0;
  localparam logic RESET_STOP_REQ = 1'b0;
  localparam logic RESET_REG_OFF = 1'b0;

endpackage

// file: src/sync_2ff.sv
// Two flip-flop synchroniser for single-bit levels.
`timescale 1ns/100ps
module sync_2ff
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Level in and out.
  input wire logic async_i,
  output logic sync_o
);

  logic meta_reg;

  // Only the second stage reads the first.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// file: testbench/fw_model.sv
// Firmware and CPU core model that writes mode request bits.
`timescale 1ns/100ps
module fw_model
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Commands from the bench.
  input wire logic req_i,
  input wire logic req_stop_i,
  input wire logic req_sel_i,
  // Request writes toward the controller.
  output logic halt_set_o,
  output logic stop_set_o,
  output logic reg_off_o,
  output logic instr_done_o
);
  // A request write is one instruction; it completes on the next cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_set_o <= 1'b0;
      stop_set_o <= 1'b0;
      reg_off_o <= 1'b0;
      instr_done_o <= 1'b0;
    end
    else
    begin
      halt_set_o <= req_i & ~req_stop_i;
      stop_set_o <= req_i & req_stop_i;
      reg_off_o <= req_i ? req_sel_i : reg_off_o;
      instr_done_o <= halt_set_o | stop_set_o;
    end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the power mode controller.
`timescale 1ns/100ps
module testbench;
  import pwr_mode_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, rq = 0, rq_stop = 0, rq_sel = 0;
  logic irq = 0, ireset = 0, pin_n = 1, sup_low = 0, cmp_en = 1;
  logic hs, ss, ro, done, run, pclk, osc, reg_en, cmp_run, crst;
  logic ld_o, rs_o, hr, sr, ld, rs;
  logic [15:0] faddr;
  logic [1:0] csel, mode;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock and timeout.
  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  fw_model fw (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(rq),
    .req_stop_i(rq_stop), .req_sel_i(rq_sel), .halt_set_o(hs),
    .stop_set_o(ss), .reg_off_o(ro), .instr_done_o(done));
  power_mode_controller uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .halt_req_set_i(hs), .stop_req_set_i(ss),
    .regulator_off_select_i(ro), .instr_done_i(done),
    .irq_enabled_pending_i(irq), .int_reset_i(ireset),
    .pin_reset_n_i(pin_n), .supply_low_i(sup_low),
    .comparator_enable_i(cmp_en), .cpu_run_o(run), .periph_clk_en_o(pclk),
    .osc_en_o(osc), .regulator_en_o(reg_en), .comparator_run_o(cmp_run),
    .core_reset_o(crst), .fetch_addr_o(faddr), .fetch_load_o(ld_o),
    .resume_next_o(rs_o), .clk_sel_o(csel), .halt_req_o(hr),
    .stop_req_o(sr), .mode_o(mode));
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task report_and_stop;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Waits for the core to run and keeps the pulses seen with it.
  task wait_run;
    int i;
    i = 0;
    do
    begin
      tick(1);
      i++;
    end
    while (run !== 1'b1 && i < 60);
    ld = ld_o;
    rs = rs_o;
    chk(run, 1'b1);
  endtask
  task wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    while (mode !== m && i < 20)
    begin
      tick(1);
      i++;
    end
    chk(mode, m);
  endtask
  task req(input logic stop, input logic sel);
    @(posedge clk_sys_i);
    rq <= 1'b1;
    rq_stop <= stop;
    rq_sel <= sel;
    @(posedge clk_sys_i);
    rq <= 1'b0;
  endtask
  task exit_ok;
    wait_run;
    chk(ld, 1'b1);
    chk(faddr, RESET_VECTOR);
    chk(csel, CLK_SEL_LOW_POWER_OSC);
    chk(mode, MODE_CODE_NORMAL);
    chk({hr, sr}, 2'h0);
    chk({osc, reg_en}, 2'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_idle_irq;
    req(1'b0, 1'b0);
    wait_mode(MODE_CODE_IDLE);
    chk({run, pclk, hr}, 3'h3);
    @(posedge clk_sys_i);
    irq <= 1'b1;
    wait_run;
    chk(rs, 1'b1);
    chk(mode, MODE_CODE_NORMAL);
    tick(2);
    chk(hr, 1'b0);
    irq <= 1'b0;
  endtask
  task t_idle_reset;
    req(1'b0, 1'b0);
    wait_mode(MODE_CODE_IDLE);
    @(posedge clk_sys_i);
    ireset <= 1'b1;
    tick(3);
    chk(crst, 1'b1);
    ireset <= 1'b0;
    exit_ok;
  endtask
  task t_stop;
    req(1'b1, 1'b0);
    wait_mode(MODE_CODE_STOP);
    chk({osc, run, pclk, reg_en, cmp_run}, 5'h3);
    cmp_en <= 1'b0;
    tick(1);
    chk(cmp_run, 1'b0);
    cmp_en <= 1'b1;
    @(posedge clk_sys_i);
    irq <= 1'b1;
    tick(10);
    chk({mode, run}, {MODE_CODE_STOP, 1'b0});
    irq <= 1'b0;
    pin_n <= 1'b0;
    tick(5);
    chk(crst, 1'b1);
    pin_n <= 1'b1;
    exit_ok;
  endtask
  task t_shutdown;
    req(1'b1, 1'b1);
    wait_mode(MODE_CODE_SHUTDOWN);
    tick(1);
    chk({reg_en, cmp_run, run}, 3'h0);
    @(posedge clk_sys_i);
    ireset <= 1'b1;
    tick(5);
    chk({mode, reg_en}, {MODE_CODE_SHUTDOWN, 1'b0});
    ireset <= 1'b0;
    sup_low <= 1'b1;
    tick(5);
    chk(crst, 1'b1);
    tick(20);
    chk({crst, run}, 2'h2);
    sup_low <= 1'b0;
    exit_ok;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    exit_ok;
    t_idle_irq;
    t_idle_reset;
    t_stop;
    t_shutdown;
    report_and_stop;
  end
endmodule
